/* File: rtl/serial_status_flags.sv */
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
`include "serial_status_flags_defs.svh"
module serial_status_flags import serial_status_pkg::*; (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // receive line and 16x sample tick from the baud generator
  input wire logic RX_PIN,
  input wire logic SAMPLE_TICK,
  // transmitter shifter side
  input wire logic TX_SHIFTER_LOAD,
  input wire logic TX_BUSY,
  output logic [7:0] TX_DATA,
  output logic TX_DATA_WRITE,
  output logic TX_PREAMBLE_REQ,
  output logic TX_ENABLE,
  output logic SEND_BREAK,
  // interrupt request
  output logic IRQ
);
  // ****************************************
  // bus slave
  // ****************************************
  logic ack;
  logic [7:0] flags;
  logic [7:0] arm;
  logic [7:0] ctrl_two;
  logic [7:0] ctrl_one;
  logic [8:0] rx_data;
  logic tx_queued;

  // every access waits one cycle so read data comes from a flop
  wire req = AVS_READ | AVS_WRITE;
  wire acc_rd = AVS_READ & ack;
  wire acc_wr = AVS_WRITE & ack & AVS_BYTEENABLE[0];
  wire status_rd = acc_rd & (AVS_ADDRESS == `OFS_STATUS);
  wire status_wr = acc_wr & (AVS_ADDRESS == `OFS_STATUS);
  wire data_rd = acc_rd & (AVS_ADDRESS == `OFS_DATA);
  wire data_wr = acc_wr & (AVS_ADDRESS == `OFS_DATA);
  wire ctwo_wr = acc_wr & (AVS_ADDRESS == `OFS_CTRL_TWO);
  wire cone_wr = acc_wr & (AVS_ADDRESS == `OFS_CTRL_ONE);
  assign AVS_WAITREQUEST = req & ~ack;

  // read mux; unmapped offsets read zero
  logic [31:0] next_readdata;
  always_comb begin
    case (AVS_ADDRESS)
      `OFS_STATUS: next_readdata = {24'h00_0000, flags};
      `OFS_DATA: next_readdata = {23'h00_0000, rx_data};
      `OFS_CTRL_TWO: next_readdata = {24'h00_0000, ctrl_two};
      `OFS_CTRL_ONE: next_readdata = {24'h00_0000, ctrl_one};
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // handshake and read data capture
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack <= 1'b0;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      ack <= req & ~ack;
      if (AVS_READ & ~ack) begin
        AVS_READDATA <= next_readdata;
      end
    end
  end

  // ****************************************
  // control registers and transmit strobes
  // ****************************************
  wire te_rise = ctwo_wr & AVS_WRITEDATA[`BIT_TX_ENABLE] & ~ctrl_two[`BIT_TX_ENABLE];
  wire brk_wr = ctwo_wr & AVS_WRITEDATA[`BIT_SEND_BREAK];
  wire queue_evt = data_wr | te_rise | brk_wr;
  assign TX_ENABLE = ctrl_two[`BIT_TX_ENABLE];
  assign SEND_BREAK = ctrl_two[`BIT_SEND_BREAK];
  wire nine_bits = ctrl_one[`BIT_NINE_BITS];
  wire idle_after_stop = ctrl_one[`BIT_IDLE_AFTER_STOP];
  wire parity_on = ctrl_one[`BIT_PARITY_ON];
  wire parity_odd = ctrl_one[`BIT_PARITY_ODD];

  // control writes; strobes are one-cycle pulses
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_two <= `CTRL_RESET;
      ctrl_one <= `CTRL_RESET;
      TX_DATA <= 8'h00;
      TX_DATA_WRITE <= 1'b0;
      TX_PREAMBLE_REQ <= 1'b0;
      tx_queued <= 1'b0;
    end else begin
      if (ctwo_wr) ctrl_two <= AVS_WRITEDATA[7:0];
      if (cone_wr) ctrl_one <= AVS_WRITEDATA[7:0];
      if (data_wr) TX_DATA <= AVS_WRITEDATA[7:0];
      TX_DATA_WRITE <= data_wr;
      TX_PREAMBLE_REQ <= te_rise;
      // held until the shifter reports activity, so the done flag cannot re-set early
      tx_queued <= queue_evt | (tx_queued & ~TX_BUSY);
    end
  end

  // ****************************************
  // receiver sampling
  // ****************************************
  logic rx_meta;
  logic rx_line;
  rx_state_e rx_state;
  rx_state_e next_rx_state;
  logic [3:0] rt;
  logic [3:0] bit_idx;
  logic [8:0] shreg;
  logic [1:0] smp;
  logic hi_seen;
  logic lo_seen;
  logic noisy;

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : maj3

  function automatic logic split3(input logic [2:0] s);
    split3 = (s != 3'h0) && (s != 3'h7);
  endfunction : split3

  wire [2:0] cur = {smp, rx_line};
  wire vote = maj3(cur);
  wire at_vote = SAMPLE_TICK & (rt == `RT_VOTE);
  wire bit_end = SAMPLE_TICK & (rt == `RT_LAST);
  wire start_smp = SAMPLE_TICK & (rt >= `RT_START_FIRST) & (rt <= `RT_VOTE);
  wire start_split = (hi_seen | rx_line) & (lo_seen | ~rx_line);
  wire [3:0] last_bit = nine_bits ? 4'h8 : 4'h7;
  wire rx_done = (rx_state == RX_STOP) & at_vote;
  wire done_noisy = noisy | split3(cur);
  wire [8:0] frame_bits = nine_bits ? shreg : {1'b0, shreg[8:1]};
  wire parity_bad = parity_on & ((^frame_bits) ^ parity_odd);

  // frame sequencing; a start bit voted high is a false start
  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      RX_IDLE: if (SAMPLE_TICK & ~rx_line) next_rx_state = RX_START;
      RX_START: begin
        if (at_vote & vote) next_rx_state = RX_IDLE;
        else if (bit_end) next_rx_state = RX_DATA;
      end
      RX_DATA: if (bit_end & (bit_idx == last_bit)) next_rx_state = RX_STOP;
      RX_STOP: if (bit_end) next_rx_state = RX_IDLE;
      default: next_rx_state = RX_IDLE;
    endcase
  end

  // line synchroniser and sampling counters
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_meta <= 1'b1;
      rx_line <= 1'b1;
      rx_state <= RX_IDLE;
      rt <= 4'h0;
      bit_idx <= 4'h0;
      smp <= 2'h3;
      shreg <= 9'h000;
      hi_seen <= 1'b0;
      lo_seen <= 1'b0;
      noisy <= 1'b0;
    end else begin
      rx_meta <= RX_PIN;
      rx_line <= rx_meta;
      rx_state <= next_rx_state;
      if (SAMPLE_TICK) smp <= cur[1:0];
      if (rx_state == RX_IDLE) begin
        rt <= 4'h1;
        bit_idx <= 4'h0;
        hi_seen <= 1'b0;
        lo_seen <= 1'b0;
        noisy <= 1'b0;
      end else if (SAMPLE_TICK) begin
        rt <= rt + 4'h1;
        if (rx_state == RX_START && start_smp) begin
          hi_seen <= hi_seen | rx_line;
          lo_seen <= lo_seen | ~rx_line;
        end
        if (rx_state == RX_START && at_vote) noisy <= start_split;
        if (rx_state == RX_DATA && at_vote) begin
          shreg <= {vote, shreg[8:1]};
          noisy <= noisy | split3(cur);
        end
        if (rx_state == RX_DATA && bit_end) bit_idx <= bit_idx + 4'h1;
      end
    end
  end

  // ****************************************
  // idle line detection
  // ****************************************
  logic [3:0] idle_ticks;
  logic [3:0] idle_bits;
  logic idle_armed;
  wire idle_len_hit = idle_bits == (nine_bits ? `IDLE_BITS_LONG : `IDLE_BITS_SHORT);
  // type 0 counts from the end of the start bit, type 1 only once back in idle
  wire idle_count_on = idle_after_stop ? (rx_state == RX_IDLE) : (rx_state != RX_START);
  wire idle_hit = idle_armed & idle_len_hit;
  wire rx_accept = rx_done & ~flags[`BIT_RX_FULL];

  // bit-time counter of high line; any low sample restarts it
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      idle_ticks <= 4'h0;
      idle_bits <= 4'h0;
      idle_armed <= 1'b0;
    end else begin
      if (SAMPLE_TICK & (~rx_line | ~idle_count_on)) begin
        idle_ticks <= 4'h0;
        idle_bits <= 4'h0;
      end else if (SAMPLE_TICK & ~idle_len_hit) begin
        idle_ticks <= idle_ticks + 4'h1;
        if (idle_ticks == `RT_LAST) idle_bits <= idle_bits + 4'h1;
      end
      // one idle report per received character
      idle_armed <= rx_accept | (idle_armed & ~idle_hit);
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  logic [7:0] set_vec;
  logic [7:0] consume;
  logic [7:0] clr_vec;
  logic [7:0] next_flags;
  logic [7:0] next_arm;
  wire tc_cond = flags[`BIT_TX_EMPTY] & ~TX_BUSY & ~tx_queued & ~queue_evt;

  // hardware events; noise, framing and parity bits only arrive with an accepted character, overrun with a refused one
  always_comb begin
    set_vec = 8'h00;
    set_vec[`BIT_TX_EMPTY] = TX_SHIFTER_LOAD;
    set_vec[`BIT_TX_DONE] = tc_cond;
    set_vec[`BIT_RX_FULL] = rx_accept;
    set_vec[`BIT_IDLE] = idle_hit;
    set_vec[`BIT_OVERRUN] = rx_done & flags[`BIT_RX_FULL];
    set_vec[`BIT_NOISE] = rx_accept & done_noisy;
    set_vec[`BIT_FRAMING] = rx_accept & ~vote;
    set_vec[`BIT_PARITY] = rx_accept & parity_bad;
  end

  // clears fire only for bits armed by an earlier status read; set wins
  assign consume = (data_wr ? `TX_CLEAR_MASK : 8'h00)
                 | ((te_rise | brk_wr) ? `TC_CLEAR_MASK : 8'h00)
                 | (data_rd ? `RX_CLEAR_MASK : 8'h00);
  assign clr_vec = arm & consume;
  // a status write has no term here, so it never touches a flag
  assign next_flags = set_vec | (flags & ~clr_vec);
  assign next_arm = status_rd ? flags : (arm & ~consume);

  // flag and arm storage; transmit flags come out of reset set
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      flags <= `STATUS_RESET;
      arm <= 8'h00;
      rx_data <= 9'h000;
    end else begin
      flags <= next_flags;
      arm <= next_arm;
      // an overrun character never reaches the data register
      if (rx_accept) rx_data <= frame_bits;
    end
  end

  // level request from enabled transmit, receive and idle flags
  assign IRQ = |(flags[7:4] & ctrl_two[7:4]);

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // transmit side and the status read snapshot
  AST_WRITE_NO_CLEAR: assert property (
    status_wr |=> ($past(flags) & ~flags & ~$past(clr_vec)) == 8'h00)
    else $error("status write cleared a flag");
  AST_TXE_SET: assert property (
    TX_SHIFTER_LOAD |=> flags[`BIT_TX_EMPTY])
    else $error("buffer-empty not set after shifter load");
  AST_TXE_HOLD: assert property (
    !TX_SHIFTER_LOAD |=> !$rose(flags[`BIT_TX_EMPTY]))
    else $error("buffer-empty set without a shifter load");
  AST_TXE_CLEAR: assert property (
    arm[`BIT_TX_EMPTY] && data_wr && !TX_SHIFTER_LOAD |=> !flags[`BIT_TX_EMPTY])
    else $error("buffer-empty not cleared by read then write");
  AST_TC_SET: assert property (
    tc_cond |=> flags[`BIT_TX_DONE])
    else $error("transmit-complete not set when idle");
  AST_TC_CLEAR: assert property (
    arm[`BIT_TX_DONE] && (te_rise || brk_wr) |=> !flags[`BIT_TX_DONE])
    else $error("transmit-complete not cleared by queue event");
  AST_TC_DATA_CLEAR: assert property (
    arm[`BIT_TX_DONE] && data_wr |=> !flags[`BIT_TX_DONE])
    else $error("transmit-complete not cleared by data write");
  AST_ARM_SNAP: assert property (
    status_rd |=> arm == $past(flags))
    else $error("arm does not match observed status");
  AST_ARM_DROP: assert property (
    data_rd && !status_rd |=> (arm & `RX_CLEAR_MASK) == 8'h00)
    else $error("receive arm survived a data read");

  // receive side; a new character and a clearing read may meet
  AST_RXF_SET: assert property (
    rx_done && !flags[`BIT_RX_FULL] |=> flags[`BIT_RX_FULL] && rx_data == $past(frame_bits))
    else $error("receive-full or data not loaded");
  AST_RX_QUIET: assert property (
    !rx_done |=> !$rose(flags[`BIT_RX_FULL]))
    else $error("receive-full set without a character");
  AST_RXF_CLEAR: assert property (
    arm[`BIT_RX_FULL] && data_rd && !rx_done |=> !flags[`BIT_RX_FULL])
    else $error("receive-full not cleared by read sequence");
  AST_IDLE_SET: assert property (
    idle_hit |=> flags[`BIT_IDLE])
    else $error("idle flag not set after idle time");
  AST_IDLE_TYPE: assert property (
    idle_after_stop && rx_state != RX_IDLE && SAMPLE_TICK |=> idle_bits == 4'h0)
    else $error("idle count ran inside a frame");
  AST_IDLE_ONCE: assert property (
    !idle_armed && !rx_accept |=> !$rose(flags[`BIT_IDLE]))
    else $error("idle flag set twice for one character");
  AST_IDLE_CLEAR: assert property (
    arm[`BIT_IDLE] && data_rd && !idle_hit |=> !flags[`BIT_IDLE])
    else $error("idle flag not cleared by read sequence");
  AST_OVERRUN: assert property (
    rx_done && flags[`BIT_RX_FULL] |=> flags[`BIT_OVERRUN] && $stable(rx_data))
    else $error("overrun not flagged or data overwritten");
  AST_OVERRUN_CLEAR: assert property (
    arm[`BIT_OVERRUN] && data_rd && !rx_done |=> !flags[`BIT_OVERRUN])
    else $error("overrun not cleared by read sequence");
  AST_ERR_KEPT: assert property (
    rx_done && flags[`BIT_RX_FULL] && !data_rd |=> $stable(flags[2:0]))
    else $error("lost character changed error flags");
  AST_NOISE_SET: assert property (
    rx_accept && done_noisy |=> flags[`BIT_NOISE])
    else $error("noise flag not set");
  AST_FRAMING_SET: assert property (
    rx_accept && !vote |=> flags[`BIT_FRAMING])
    else $error("framing error not set");
  AST_PARITY_SET: assert property (
    rx_accept && parity_bad |=> flags[`BIT_PARITY])
    else $error("parity error not set");
  AST_ERR_WITH_FULL: assert property (
    $rose(flags[`BIT_NOISE]) || $rose(flags[`BIT_FRAMING]) |-> $rose(flags[`BIT_RX_FULL]))
    else $error("error flag set without receive-full");
  AST_PARITY_ON: assert property (
    $rose(flags[`BIT_PARITY]) |-> $past(parity_on) && $rose(flags[`BIT_RX_FULL]))
    else $error("parity error set while parity off");
  AST_RX_ERR_CLEAR: assert property (
    data_rd && !rx_done |=> (flags[2:0] & $past(arm[2:0])) == 3'h0)
    else $error("receive error flags not cleared");

  // main scenarios reached
  COV_OVERRUN: cover property (rx_done && flags[`BIT_RX_FULL]);
  COV_IDLE: cover property (idle_hit);
  COV_BREAK_CLEAR: cover property (arm[6] && brk_wr);
  COV_NOISY: cover property (rx_accept && done_noisy);
  COV_NINE_BIT: cover property (rx_accept && nine_bits);
endmodule : serial_status_flags

/* File: rtl/serial_status_flags_defs.svh */
`ifndef SERIAL_STATUS_FLAGS_DEFS_SVH
`define SERIAL_STATUS_FLAGS_DEFS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define OFS_STATUS 4'h0
`define OFS_DATA 4'h4
`define OFS_CTRL_TWO 4'h8
`define OFS_CTRL_ONE 4'hC
// ****************************************
// status bit positions and reset value
// ****************************************
`define BIT_TX_EMPTY 7
`define BIT_TX_DONE 6
`define BIT_RX_FULL 5
`define BIT_IDLE 4
`define BIT_OVERRUN 3
`define BIT_NOISE 2
`define BIT_FRAMING 1
`define BIT_PARITY 0
`define STATUS_RESET 8'hC0
`define TX_CLEAR_MASK 8'hC0
`define TC_CLEAR_MASK 8'h40
`define RX_CLEAR_MASK 8'h3F
// ****************************************
// control fields and reset values
// ****************************************
`define CTRL_RESET 8'h00
`define BIT_TX_ENABLE 3
`define BIT_SEND_BREAK 0
`define BIT_NINE_BITS 4
`define BIT_IDLE_AFTER_STOP 2
`define BIT_PARITY_ON 1
`define BIT_PARITY_ODD 0
// ****************************************
// receiver timing counts
// ****************************************
`define RT_LAST 4'hF
`define RT_START_FIRST 4'h4
`define RT_VOTE 4'hA
`define IDLE_BITS_SHORT 4'hA
`define IDLE_BITS_LONG 4'hB
`endif

/* File: rtl/serial_status_pkg.sv */
package serial_status_pkg;
  // receiver frame position
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
endpackage : serial_status_pkg

/* File: verification/serial_node_model.sv */
`timescale 1ns/10ps
// ****************************************
// remote node driving the receive line
// ****************************************
module serial_node_model (
  // clock and baud tick
  input wire logic CLK,
  input wire logic SAMPLE_TICK,
  // serial line toward the block
  output logic RX_PIN
);
  // line rests high between frames, as a real idle line does
  initial begin
    RX_PIN = 1'b1;
  end

  // wait a number of 16x sample ticks
  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK);
      // the tick comes every other cycle; the bound keeps a stuck tick from hanging
      for (int w = 0; w < 16 && SAMPLE_TICK !== 1'b1; w++) @(posedge CLK);
    end
  endtask : ticks

  // start bit, data lsb first, then the stop level and a gap of two bit times
  task automatic send(input logic [8:0] data, input int nbits, input logic stop,
                      input logic noisy);
    logic bit_v;
    for (int b = 0; b < nbits + 2; b++) begin
      bit_v = (b == 0) ? 1'b0 : (b > nbits) ? stop : data[b-1];
      RX_PIN <= bit_v;
      if (noisy && b == 1) begin
        // one-tick glitch in the middle of the first data bit
        ticks(9);
        RX_PIN <= ~bit_v;
        ticks(1);
        RX_PIN <= bit_v;
        ticks(6);
      end else begin
        ticks(16);
      end
    end
    RX_PIN <= 1'b1;
    ticks(32);
  endtask : send
endmodule : serial_node_model

/* File: verification/serial_status_flags_tb.sv */
`timescale 1ns/10ps
`include "serial_status_flags_defs.svh"
module serial_status_flags_tb import serial_status_pkg::*;;
  logic clk, resetn, avs_read, avs_write, avs_waitrequest, rx_pin, sample_tick;
  logic tx_load, tx_busy, irq;
  logic tx_dwr, tx_pre, tx_en, tx_brk;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0] tx_data;
  int failures, total_checks;

  // ****************************************
  // clock, tick and time-zero values
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // tick every other cycle keeps a frame short
  always @(posedge clk or negedge resetn) begin
    if (!resetn) sample_tick <= 1'b0;
    else sample_tick <= ~sample_tick;
  end

  serial_status_flags dut (.CLK(clk), .RESETN(resetn), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(4'h1), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .RX_PIN(rx_pin), .SAMPLE_TICK(sample_tick), .TX_SHIFTER_LOAD(tx_load),
    .TX_BUSY(tx_busy), .TX_DATA(tx_data), .TX_DATA_WRITE(tx_dwr), .TX_PREAMBLE_REQ(tx_pre),
    .TX_ENABLE(tx_en), .SEND_BREAK(tx_brk), .IRQ(irq));
  serial_node_model node (.CLK(clk), .SAMPLE_TICK(sample_tick), .RX_PIN(rx_pin));

  // ****************************************
  // report and bus helpers
  // ****************************************
  task automatic finish_test;
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8

  // one avalon transfer; an extra edge after release keeps drivers from colliding
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [7:0] wdata,
                     output logic [7:0] rdata);
    logic ok;
    avs_address <= addr;
    avs_writedata <= {24'h00_0000, wdata};
    avs_read <= ~wr;
    avs_write <= wr;
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge clk);
      ok = (avs_waitrequest === 1'b0);
    end
    rdata = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (!ok) begin
      failures++;
      finish_test();
    end
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [3:0] addr, input logic [7:0] wdata);
    logic [7:0] d;
    bus(1'b1, addr, wdata, d);
  endtask : wr

  task automatic rdchk(input logic [3:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    bus(1'b0, addr, 8'h00, d);
    check8(d, exp);
  endtask : rdchk

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_irq;
    rdchk(`OFS_STATUS, `STATUS_RESET);
    wr(`OFS_STATUS, 8'h00);
    rdchk(`OFS_STATUS, 8'hC0);
    wr(`OFS_CTRL_TWO, 8'h80);
    check8({7'h00, irq}, 8'h01);
    wr(`OFS_CTRL_TWO, 8'h00);
    check8({7'h00, irq}, 8'h00);
  endtask : t_reset_irq

  // data write, break write and enable rise, each after a status read
  task automatic t_tx;
    logic [3:0] addrs [3] = '{`OFS_DATA, `OFS_CTRL_TWO, `OFS_CTRL_TWO};
    logic [7:0] vals [3] = '{8'h55, 8'h01, 8'h08};
    logic [7:0] strobe_exp [3] = '{8'h08, 8'h01, 8'h06};
    for (int i = 0; i < 3; i++) begin
      rdchk(`OFS_STATUS, 8'hC0);
      wr(addrs[i], vals[i]);
      // strobes stand for the cycle after the write, controls stay
      check8({4'h0, tx_dwr, tx_pre, tx_en, tx_brk}, strobe_exp[i]);
      rdchk(`OFS_STATUS, (i == 0) ? 8'h00 : 8'h80);
      if (i == 0) check8(tx_data, 8'h55);
      tx_load <= 1'b1;
      tx_busy <= 1'b1;
      @(posedge clk);
      tx_load <= 1'b0;
      @(posedge clk);
      rdchk(`OFS_STATUS, 8'h80);
      tx_busy <= 1'b0;
      wr(`OFS_CTRL_TWO, 8'h00);
      repeat (2) @(posedge clk);
      rdchk(`OFS_STATUS, 8'hC0);
    end
  endtask : t_tx

  // one frame, then idle; flags read, data read, flags gone
  task automatic rx_case(input logic [8:0] data, input logic stop, input logic noisy,
                         input logic [7:0] flags, input logic [7:0] exp_data);
    node.send(data, 8, stop, noisy);
    repeat (400) @(posedge clk);
    rdchk(`OFS_STATUS, 8'hF0 | flags);
    rdchk(`OFS_DATA, exp_data);
    rdchk(`OFS_STATUS, 8'hC0);
  endtask : rx_case

  task automatic t_rx_basic;
    rdchk(`OFS_STATUS, 8'hC0);
    node.send(9'h0A5, 8, 1'b1, 1'b0);
    repeat (400) @(posedge clk);
    rdchk(`OFS_DATA, 8'hA5);
    rdchk(`OFS_STATUS, 8'hF0);
    rdchk(`OFS_DATA, 8'hA5);
    rdchk(`OFS_STATUS, 8'hC0);
    repeat (400) @(posedge clk);
    rdchk(`OFS_STATUS, 8'hC0);
  endtask : t_rx_basic

  task automatic t_rx_errors;
    rx_case(9'h0FF, 1'b1, 1'b1, 8'h04, 8'hFF);
    rx_case(9'h03C, 1'b0, 1'b0, 8'h02, 8'h3C);
    node.send(9'h011, 8, 1'b1, 1'b0);
    rx_case(9'h022, 1'b1, 1'b0, 8'h08, 8'h11);
    wr(`OFS_CTRL_ONE, 8'h02);
    rx_case(9'h001, 1'b1, 1'b0, 8'h01, 8'h01);
    wr(`OFS_CTRL_ONE, 8'h03);
    rx_case(9'h001, 1'b1, 1'b0, 8'h00, 8'h01);
    wr(`OFS_CTRL_ONE, 8'h00);
  endtask : t_rx_errors

  // nine bits, idle counted only after the stop bit; all-ones data would
  // already count as idle under the other idle type
  task automatic t_rx_nine;
    wr(`OFS_CTRL_ONE, 8'h14);
    node.send(9'h1FF, 9, 1'b1, 1'b0);
    repeat (200) @(posedge clk);
    rdchk(`OFS_STATUS, 8'hE0);
    repeat (200) @(posedge clk);
    rdchk(`OFS_STATUS, 8'hF0);
    rdchk(`OFS_DATA, 8'hFF);
    check8({7'h00, avs_readdata[8]}, 8'h01);
    rdchk(`OFS_STATUS, 8'hC0);
    wr(`OFS_CTRL_ONE, 8'h00);
  endtask : t_rx_nine

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    failures = 0;
    total_checks = 0;
    resetn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    tx_load = 1'b0;
    tx_busy = 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_reset_irq();
    t_tx();
    t_rx_basic();
    t_rx_errors();
    t_rx_nine();
    finish_test();
  end
endmodule : serial_status_flags_tb
